// ---- src/iwg_pkg.sv ----
// shared constants and types of the interval waveform generator
// assumes a 32-bit classic wishbone register bus with byte addresses
`default_nettype none

package iwg_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_REPEAT = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_TABLE = 8'h40;
  localparam logic [1:0] TABLE_PAGE = 2'h1;

  // interval table
  localparam int unsigned TABLE_DEPTH = 16;
  localparam int unsigned TABLE_IDX_W = 4;

  // field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CFG_FLAGS_LSB = 0;
  localparam int unsigned CFG_GENERAL_BIT = 8;
  localparam int unsigned CFG_PSC_LSB = 16;
  localparam int unsigned FLAG_LEVEL_BIT = 0;
  localparam int unsigned FLAG_MOD_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_REFUSED_BIT = 2;
  localparam int unsigned STAT_LEVEL_BIT = 3;
  localparam int unsigned STAT_SEG_LSB = 16;

  // reset values
  localparam logic [15:0] COUNT_RST = 16'h0001;
  localparam logic [15:0] REPEAT_RST = 16'h0000;
  localparam logic [15:0] INTERVAL_RST = 16'h0001;

  // prescaler terminal counts for select codes 0..4 (divide by 1, 8, 64, 256, 1024)
  localparam logic [9:0] PSC_TERM_0 = 10'h000;
  localparam logic [9:0] PSC_TERM_1 = 10'h007;
  localparam logic [9:0] PSC_TERM_2 = 10'h03F;
  localparam logic [9:0] PSC_TERM_3 = 10'h0FF;
  localparam logic [9:0] PSC_TERM_4 = 10'h3FF;

  typedef struct packed {
    logic [2:0] psc_sel;
    logic general_pin;
    logic [7:0] flags;
  } iwg_cfg_t;

  localparam iwg_cfg_t CFG_RST = '{psc_sel: 3'h0, general_pin: 1'b0, flags: 8'h00};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM = 3'b010,
    ST_RUN = 3'b100
  } iwg_state_t;
endpackage

`default_nettype wire

// ---- src/iwg_tick_gen.sv ----
// interval prescaler: one-cycle tick every 1, 8, 64, 256 or 1024 clocks
// assumes sel and clear come from logic on the same clock
`default_nettype none

module iwg_tick_gen (
  input wire logic clock,  // system clock
  input wire logic reset_n,  // async reset, active low
  input wire logic clear,  // restart the division phase
  input wire logic [2:0] sel,  // interval_prescaler_select
  output logic tick  // one-cycle tick
);
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic [9:0] term;

  assign term = (sel == 3'h0) ? iwg_pkg::PSC_TERM_0 :
                (sel == 3'h1) ? iwg_pkg::PSC_TERM_1 :
                (sel == 3'h2) ? iwg_pkg::PSC_TERM_2 :
                (sel == 3'h3) ? iwg_pkg::PSC_TERM_3 : iwg_pkg::PSC_TERM_4;
  assign tick = ~clear & (cnt_q == term);
  assign cnt_d = (clear | tick) ? 10'h000 : cnt_q + 10'h001;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

`default_nettype wire

// ---- src/iwg_seg_timer.sv ----
// 16-bit compare timer: match pulses on the tick that ends a loaded interval
// a value of zero lasts 65536 ticks, since the compare wraps
`default_nettype none

module iwg_seg_timer (
  input wire logic clock,  // system clock
  input wire logic reset_n,  // async reset, active low
  input wire logic tick,  // prescaled tick
  input wire logic load,  // start a new interval
  input wire logic stop,  // halt the timer
  input wire logic [15:0] value,  // interval in ticks
  output logic match  // one-cycle end of interval
);
  logic [15:0] cnt_q;
  logic [15:0] cmp_q;
  logic run_q;
  logic [15:0] cnt_inc;

  assign cnt_inc = cnt_q + 16'h0001;
  assign match = run_q & tick & (cnt_inc == cmp_q);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 16'h0000;
      cmp_q <= 16'h0000;
      run_q <= 1'b0;
    end else if (load) begin
      cnt_q <= 16'h0000;
      cmp_q <= value;
      run_q <= 1'b1;
    end else if (stop | match) begin
      cnt_q <= 16'h0000;
      run_q <= ~stop & ~match;
    end else if (run_q & tick) begin
      cnt_q <= cnt_inc;
    end
  end
endmodule

`default_nettype wire

// ---- src/iwg_top.sv ----
// interval waveform generator: wishbone slave, interval table and sequencer
// assumes all inputs come from logic on the same clock; the pin pad is outside
//
// Behaviour
// RULE_01 - each table value gives the length of one segment in prescaled timer ticks.
// RULE_02 - on acceptance the pin is made an output at the inverse of flag bit 0.
// RULE_03 - every segment start inverts the pin and holds it for that interval, in table order.
// RULE_04 - the final level is the inverse of flag bit 0 for an odd count and equal to it for even.
// RULE_05 - the host gives an interval count of 1 to 65535.
// RULE_06 - a repeat total of 1 to 65535 may be given, and zero means one single run.
// RULE_07 - with repeats the last interval of the last pass is skipped so the pin ends where it began.
// RULE_08 - the host should use an odd count for one run and an even count when repeating.
// RULE_09 - the host should not ask for segments shorter than about 100 processor cycles.
// RULE_10 - flag value 0x02 gates the carrier with the waveform and enables its compare output at start.
// RULE_11 - the host sets up the carrier timer, leaves its output off and marks it in use beforehand.
// RULE_12 - a request while the interval timer is in use ends at once with no pin change.
// RULE_13 - the dedicated pin is toggled by the compare match, a general pin by its port output bit.
// RULE_14 - for a general pin the shared 16-bit timer supplies the segment timing.
// RULE_15 - the host leaves the pin as input or at the starting level before a request.
// RULE_16 - longer segments are had by selecting a slower prescaler tick.
// RULE_17 - busy shows from acceptance to the end of the last segment, then the timer is freed and done set.
//
// Local design decisions: the Wishbone register port and the register offsets.
`default_nettype none

module iwg_top (
  input wire logic clock,  // system clock, 200 MHz
  input wire logic reset_n,  // async reset, active low
  input wire logic wb_cyc_i,  // wishbone cycle
  input wire logic wb_stb_i,  // wishbone strobe
  input wire logic wb_we_i,  // wishbone write enable
  input wire logic [7:0] wb_adr_i,  // wishbone byte address
  input wire logic [3:0] wb_sel_i,  // wishbone byte lanes
  input wire logic [31:0] wb_dat_i,  // wishbone write data
  output logic [31:0] wb_dat_o,  // wishbone read data
  output logic wb_ack_o,  // wishbone acknowledge
  input wire logic interval_timer_in_use,  // interval timer held by another user
  input wire logic carrier_timer_in_use,  // carrier timer prepared and marked in use
  input wire logic carrier_wave,  // carrier from the separate timer
  output logic waveform_output_pin,  // dedicated waveform pin level
  output logic waveform_output_pin_oe,  // dedicated pin output enable
  output logic port_output_bit,  // general pin port output bit
  output logic port_output_oe,  // general pin direction, high drives
  output logic carrier_compare_out_a,  // gated carrier output
  output logic carrier_out_en,  // carrier compare output enabled
  output logic interval_timer_claim  // interval timer taken by this block
);
  // bus decode
  logic req;
  logic wr;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_count;
  logic wr_repeat;
  logic wr_status;
  logic wr_table;
  logic in_table;
  logic [iwg_pkg::TABLE_IDX_W-1:0] tbl_widx;
  logic [31:0] rd_data;
  logic [31:0] ack_d;

  // stored registers
  iwg_pkg::iwg_cfg_t cfg_q;
  logic [15:0] count_q;
  logic [15:0] repeat_q;
  logic [15:0] table_q [iwg_pkg::TABLE_DEPTH];
  logic done_q;
  logic refused_q;

  // sequencer
  iwg_pkg::iwg_state_t state_q;
  iwg_pkg::iwg_state_t state_d;
  logic [15:0] seg_idx_q;
  logic [15:0] seg_idx_inc;
  logic [31:0] segs_done_q;
  logic [31:0] segs_inc;
  logic [31:0] total_q;
  logic [31:0] total_d;
  logic [15:0] rep_eff;
  logic [31:0] product;
  logic level_q;
  logic mod_q;

  logic busy;
  logic start_req;
  logic accept;
  logic refuse;
  logic seg_start;
  logic last_seg;
  logic finish;
  logic toggle;
  logic arm;
  logic tick;
  logic match;
  logic [15:0] cur_interval;
  logic [31:0] cfg_word;
  logic [31:0] status_word;
  logic [31:0] cfg_merged;

  // output flops
  logic [31:0] dat_q;
  logic ack_q;
  logic pin_q;
  logic pin_oe_q;
  logic port_q;
  logic port_oe_q;
  logic carrier_q;
  logic carrier_en_q;
  logic claim_q;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] lanes);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // one-cycle ack per request; the following cycle is always idle on the bus
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign in_table = (wb_adr_i[7:6] == iwg_pkg::TABLE_PAGE);
  assign tbl_widx = wb_adr_i[5:2];
  assign wr_ctrl = wr & (wb_adr_i == iwg_pkg::OFS_CTRL);
  assign wr_cfg = wr & (wb_adr_i == iwg_pkg::OFS_CFG);
  assign wr_count = wr & (wb_adr_i == iwg_pkg::OFS_COUNT);
  assign wr_repeat = wr & (wb_adr_i == iwg_pkg::OFS_REPEAT);
  assign wr_status = wr & (wb_adr_i == iwg_pkg::OFS_STATUS);
  assign wr_table = wr & in_table;
  assign ack_d = 32'h0000_0000;

  assign busy = (state_q != iwg_pkg::ST_IDLE);
  assign cfg_word = {13'h0000, cfg_q.psc_sel, 7'h00, cfg_q.general_pin, cfg_q.flags};
  assign cfg_merged = merge(cfg_word, wb_dat_i, wb_sel_i);
  assign status_word = {seg_idx_q, 12'h000, level_q, refused_q, done_q, busy};

  assign rd_data = (wb_adr_i == iwg_pkg::OFS_CFG) ? cfg_word :
                   (wb_adr_i == iwg_pkg::OFS_COUNT) ? {16'h0000, count_q} :
                   (wb_adr_i == iwg_pkg::OFS_REPEAT) ? {16'h0000, repeat_q} :
                   (wb_adr_i == iwg_pkg::OFS_STATUS) ? status_word :
                   in_table ? {16'h0000, table_q[tbl_widx]} : ack_d;

  // start request and its admission
  assign start_req = wr_ctrl & wb_sel_i[0] & wb_dat_i[iwg_pkg::CTRL_START_BIT];
  // a modulated run also needs the carrier timer prepared by the host
  assign refuse = start_req & ~busy & (interval_timer_in_use | (count_q == 16'h0000) |
                  (cfg_q.flags[iwg_pkg::FLAG_MOD_BIT] & ~carrier_timer_in_use)); // RULE_12
  assign accept = start_req & ~busy & ~refuse;

  // segment count: count times repeats, less the skipped final interval when repeating
  assign rep_eff = (repeat_q == 16'h0000) ? 16'h0001 : repeat_q; // RULE_06
  assign product = count_q * rep_eff;
  assign total_d = (rep_eff > 16'h0001) ? product - 32'h0000_0001 : product; // RULE_07

  assign segs_inc = segs_done_q + 32'h0000_0001;
  assign last_seg = (segs_inc == total_q);
  assign seg_idx_inc = seg_idx_q + 16'h0001;
  // table is a ring: counts above its depth reuse entries the host may refill meanwhile
  assign cur_interval = table_q[seg_idx_q[iwg_pkg::TABLE_IDX_W-1:0]]; // RULE_03
  assign seg_start = (state_q == iwg_pkg::ST_ARM) |
                     ((state_q == iwg_pkg::ST_RUN) & match & ~last_seg); // RULE_03
  assign finish = (state_q == iwg_pkg::ST_RUN) & match & last_seg; // RULE_17
  assign arm = (state_q == iwg_pkg::ST_ARM);
  // the end of the last segment turns the pin once more, so an odd count ends at the inverse of flag bit 0
  assign toggle = seg_start | finish; // RULE_04

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      iwg_pkg::ST_IDLE: begin
        if (accept) begin
          state_d = iwg_pkg::ST_ARM;
        end
      end
      iwg_pkg::ST_ARM: begin
        state_d = iwg_pkg::ST_RUN;
      end
      iwg_pkg::ST_RUN: begin
        if (finish) begin
          state_d = iwg_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // prescaler restarts in the arm cycle, as the timer loads, so the first segment is a whole number of ticks
  iwg_tick_gen u_tick (
    .clock(clock),
    .reset_n(reset_n),
    .clear(arm),
    .sel(cfg_q.psc_sel), // RULE_01
    .tick(tick)
  );

  // one 16-bit compare timer serves both the dedicated and the general pin
  iwg_seg_timer u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .tick(tick),
    .load(seg_start), // RULE_14
    .stop(accept),
    .value(cur_interval), // RULE_01
    .match(match)
  );

  // wishbone slave
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= req ? rd_data : 32'h0000_0000;
    end
  end

  // configuration is frozen while a waveform runs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= iwg_pkg::CFG_RST;
      count_q <= iwg_pkg::COUNT_RST;
      repeat_q <= iwg_pkg::REPEAT_RST;
    end else if (!busy) begin
      if (wr_cfg) begin
        cfg_q.flags <= cfg_merged[iwg_pkg::CFG_FLAGS_LSB +: 8];
        cfg_q.general_pin <= cfg_merged[iwg_pkg::CFG_GENERAL_BIT];
        cfg_q.psc_sel <= cfg_merged[iwg_pkg::CFG_PSC_LSB +: 3]; // RULE_16
      end
      if (wr_count) begin
        count_q <= 16'(merge({16'h0000, count_q}, wb_dat_i, wb_sel_i));
      end
      if (wr_repeat) begin
        repeat_q <= 16'(merge({16'h0000, repeat_q}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // interval table, writable at any time
  for (genvar g = 0; g < iwg_pkg::TABLE_DEPTH; g++) begin : g_table
    logic [31:0] tbl_merged;
    assign tbl_merged = merge({16'h0000, table_q[g]}, wb_dat_i, wb_sel_i);
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        table_q[g] <= iwg_pkg::INTERVAL_RST;
      end else if (wr_table && (int'(tbl_widx) == g)) begin
        table_q[g] <= tbl_merged[15:0];
      end
    end
  end

  // sticky status: a hardware set in the clearing cycle wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_q <= finish | (done_q & ~(wr_status & wb_sel_i[0] & wb_dat_i[iwg_pkg::STAT_DONE_BIT])); // RULE_17
      refused_q <= refuse |
                   (refused_q & ~(wr_status & wb_sel_i[0] & wb_dat_i[iwg_pkg::STAT_REFUSED_BIT])); // RULE_12
    end
  end

  // sequencer state and counters
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= iwg_pkg::ST_IDLE;
      seg_idx_q <= 16'h0000;
      segs_done_q <= 32'h0000_0000;
      total_q <= 32'h0000_0000;
      mod_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (accept) begin
        seg_idx_q <= 16'h0000;
        segs_done_q <= 32'h0000_0000;
        total_q <= total_d; // RULE_07
        mod_q <= cfg_q.flags[iwg_pkg::FLAG_MOD_BIT];
      end else begin
        if (seg_start) begin
          seg_idx_q <= (seg_idx_inc == count_q) ? 16'h0000 : seg_idx_inc; // RULE_06
        end
        if ((state_q == iwg_pkg::ST_RUN) && match) begin
          segs_done_q <= segs_inc;
        end
      end
    end
  end

  // waveform level: set to the inverse of flag bit 0, then inverted at each segment start
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= 1'b0;
    end else if (accept) begin
      level_q <= ~cfg_q.flags[iwg_pkg::FLAG_LEVEL_BIT]; // RULE_02
    end else if (toggle) begin
      level_q <= ~level_q; // RULE_04
    end
  end

  // dedicated pin: toggled straight from the compare match so the edge has fixed latency
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else if (accept && !cfg_q.general_pin) begin
      pin_q <= ~cfg_q.flags[iwg_pkg::FLAG_LEVEL_BIT]; // RULE_02
      pin_oe_q <= 1'b1;
    end else if (toggle && !cfg_q.general_pin) begin
      pin_q <= ~pin_q; // RULE_13
    end
  end

  // general pin: the port output bit itself is rewritten at each segment start
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port_q <= 1'b0;
      port_oe_q <= 1'b0;
    end else if (accept && cfg_q.general_pin) begin
      port_q <= ~cfg_q.flags[iwg_pkg::FLAG_LEVEL_BIT]; // RULE_02
      port_oe_q <= 1'b1;
    end else if (toggle && cfg_q.general_pin) begin
      port_q <= ~level_q; // RULE_13
    end
  end

  // carrier gating and timer claim; pins stay driven at their final level after the run
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      carrier_q <= 1'b0;
      carrier_en_q <= 1'b0;
      claim_q <= 1'b0;
    end else begin
      carrier_q <= busy & mod_q & carrier_wave & level_q; // RULE_10
      if (accept) begin
        carrier_en_q <= cfg_q.flags[iwg_pkg::FLAG_MOD_BIT]; // RULE_10
        claim_q <= 1'b1; // RULE_17
      end else if (finish) begin
        carrier_en_q <= 1'b0;
        claim_q <= 1'b0; // RULE_17
      end
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign waveform_output_pin = pin_q;
  assign waveform_output_pin_oe = pin_oe_q;
  assign port_output_bit = port_q;
  assign port_output_oe = port_oe_q;
  assign carrier_compare_out_a = carrier_q;
  assign carrier_out_en = carrier_en_q;
  assign interval_timer_claim = claim_q;
endmodule

`default_nettype wire

// ---- testbench/iwg_carrier_model.sv ----
// carrier timer model: free-running square wave, marked in use on request
// assumes the bench raises ready before a modulated start
`default_nettype none

module iwg_carrier_model #(
  parameter int HALF = 3
) (
  input wire logic clock,  // system clock
  input wire logic reset_n,  // async reset
  input wire logic ready,  // carrier set up
  output logic carrier_timer_in_use,  // carrier marked in use
  output logic carrier_wave  // carrier level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic wave_q;

  // the timer runs set up ahead of time; its output is enabled by the device
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 4'h0;
      wave_q <= 1'b0;
    end else if (cnt_q == 4'(HALF - 1)) begin
      cnt_q <= 4'h0;
      wave_q <= ~wave_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign carrier_timer_in_use = ready;
  assign carrier_wave = wave_q;
endmodule

`default_nettype wire

// ---- testbench/iwg_top_asserts.sv ----
// port checker for iwg_top: bus timing and waveform sequencing
// assumes one clock domain and the async active-low reset
`default_nettype none

module iwg_top_asserts (
  input wire logic clock,  // clock
  input wire logic reset_n,  // reset
  input wire logic wb_cyc_i,  // cycle
  input wire logic wb_stb_i,  // strobe
  input wire logic [31:0] wb_dat_o,  // read data
  input wire logic wb_ack_o,  // ack
  input wire logic interval_timer_in_use,  // timer owned elsewhere
  input wire logic carrier_wave,  // carrier
  input wire logic waveform_output_pin,  // pin
  input wire logic waveform_output_pin_oe,  // pin enable
  input wire logic port_output_bit,  // general pin
  input wire logic port_output_oe,  // general enable
  input wire logic carrier_compare_out_a,  // gated carrier
  input wire logic carrier_out_en,  // carrier enable
  input wire logic interval_timer_claim  // run owns timer
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_refuse_busy: assert property ($rose(interval_timer_claim) |-> !$past(interval_timer_in_use))
    else $error("run started on a timer in use");
  a_oe_start: assert property ($rose(interval_timer_claim) |-> waveform_output_pin_oe || port_output_oe)
    else $error("pin not driven at start");
  a_first_toggle: assert property ($rose(interval_timer_claim) |=>
    (waveform_output_pin != $past(waveform_output_pin)) || (port_output_bit != $past(port_output_bit)))
    else $error("first segment did not toggle");
  a_carrier_run: assert property (carrier_out_en |-> interval_timer_claim)
    else $error("carrier enabled outside a run");
  a_gate_wave: assert property (carrier_compare_out_a |-> $past(carrier_wave))
    else $error("gated output without carrier");
  a_pins_idle: assert property (!interval_timer_claim && !$past(interval_timer_claim) |->
    $stable(waveform_output_pin) && $stable(port_output_bit))
    else $error("pin moved while idle");
endmodule

`default_nettype wire

// ---- testbench/iwg_top_bench.sv ----
// self-checking bench for iwg_top: table of runs, then refusal and reset cases
// assumes the carrier model stands in for the separate carrier timer
`default_nettype none

module iwg_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] fl; logic g; logic [2:0] ps; logic [15:0] cnt; logic [15:0] rep;} iwg_row_t;
  // counts stay within 1..65535; odd for single runs except one even case
  localparam iwg_row_t ROWS [5] = '{'{8'h00, 1'b0, 3'h0, 16'h0001, 16'h0000},
    '{8'h01, 1'b0, 3'h1, 16'h0002, 16'h0000}, '{8'h00, 1'b1, 3'h0, 16'h0002, 16'h0003},
    '{8'h03, 1'b0, 3'h0, 16'h0003, 16'h0001}, '{8'h01, 1'b1, 3'h2, 16'h0001, 16'h0001}};
  localparam logic [7:0] RA [6] = '{iwg_pkg::OFS_CFG, iwg_pkg::OFS_COUNT, iwg_pkg::OFS_REPEAT,
    iwg_pkg::OFS_STATUS, iwg_pkg::OFS_TABLE, 8'h20};
  localparam logic [31:0] RV [6] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h1, 32'h0};
  logic clock, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, interval_timer_in_use, mod_rdy, gen;
  logic carrier_timer_in_use, carrier_wave, waveform_output_pin, waveform_output_pin_oe, port_output_bit;
  logic port_output_oe, carrier_compare_out_a, carrier_out_en, interval_timer_claim, prev_claim, prev_pin;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int err_total = 0;
  int n_checks = 0;
  int toggles = 0, busy_cyc = 0, mod_cyc = 0;
  wire logic sel_pin;

  assign sel_pin = gen ? port_output_bit : waveform_output_pin;
  always #2.5 clock = ~clock;

  iwg_top uut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .interval_timer_in_use(interval_timer_in_use), .carrier_timer_in_use(carrier_timer_in_use),
    .carrier_wave(carrier_wave), .waveform_output_pin(waveform_output_pin), .port_output_bit(port_output_bit),
    .waveform_output_pin_oe(waveform_output_pin_oe), .port_output_oe(port_output_oe),
    .carrier_compare_out_a(carrier_compare_out_a), .carrier_out_en(carrier_out_en),
    .interval_timer_claim(interval_timer_claim));
  iwg_carrier_model carrier (.clock(clock), .reset_n(reset_n), .ready(mod_rdy),
    .carrier_timer_in_use(carrier_timer_in_use), .carrier_wave(carrier_wave));

  // the first level set on acceptance is not a toggle, so only count once a run is under way
  always @(posedge clock) begin
    prev_claim <= interval_timer_claim;
    prev_pin <= sel_pin;
    if (prev_claim === 1'b1 && sel_pin !== prev_pin) toggles <= toggles + 1;
    if (interval_timer_claim === 1'b1) busy_cyc <= busy_cyc + 1;
    if (carrier_compare_out_a === 1'b1) mod_cyc <= mod_cyc + 1;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk("wb_ack_o", 32'h1, 32'h0);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clock);
  endtask

  task automatic run_row(input iwg_row_t r);
    int t0, b0, m0, nseg, sum, dv, n;
    logic lvl;
    gen <= r.g;
    mod_rdy <= r.fl[1];
    wb_xfer(1'b1, iwg_pkg::OFS_CFG, {13'h0, r.ps, 7'h0, r.g, r.fl});
    wb_xfer(1'b1, iwg_pkg::OFS_COUNT, {16'h0, r.cnt});
    wb_xfer(1'b1, iwg_pkg::OFS_REPEAT, {16'h0, r.rep});
    nseg = int'(r.cnt) * ((r.rep == 16'h0) ? 1 : int'(r.rep)) - ((r.rep > 16'h1) ? 1 : 0);
    dv = 1 << (3 * int'(r.ps));
    sum = 0;
    for (int k = 0; k < nseg; k++) sum += 100 + (k % int'(r.cnt)) % 16;
    lvl = r.fl[0] ^ nseg[0];
    t0 = toggles;
    b0 = busy_cyc;
    m0 = mod_cyc;
    wb_xfer(1'b1, iwg_pkg::OFS_CTRL, 32'h1);
    n = 0;
    while (interval_timer_claim === 1'b1 && n < 50000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50000) chk("run end", 32'h1, 32'h0);
    repeat (2) @(posedge clock);
    chk("toggle count", 32'(nseg + 1), 32'(toggles - t0));
    chk("busy cycles", 32'(1 + dv * sum), 32'(busy_cyc - b0));
    chk("final level", {31'h0, lvl}, {31'h0, sel_pin});
    chk("carrier gated", {31'h0, r.fl[1]}, {31'h0, mod_cyc != m0});
    chk("pin enable", 32'h1, {31'h0, r.g ? port_output_oe : waveform_output_pin_oe});
    chk("carrier off", 32'h0, {31'h0, carrier_out_en});
    wb_xfer(1'b0, iwg_pkg::OFS_STATUS, 32'h0);
    chk("status", {28'h0, lvl, 3'b010}, {28'h0, rd[3:0]});
    wb_xfer(1'b1, iwg_pkg::OFS_STATUS, 32'h2);
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    complete_run();
  end

  initial begin
    {clock, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, interval_timer_in_use, mod_rdy, gen} = 8'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
    repeat (20) @(posedge clock);
    chk("outputs in reset", 32'h0, {27'h0, wb_ack_o, waveform_output_pin_oe, port_output_oe,
      carrier_out_en, interval_timer_claim});
    reset_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      wb_xfer(1'b0, RA[i], 32'h0);
      chk("reset value", RV[i], rd);
    end
    // segments kept at 100 ticks or more
    for (int i = 0; i < 16; i++) wb_xfer(1'b1, iwg_pkg::OFS_TABLE + 8'(4 * i), 32'(100 + i));
    foreach (ROWS[i]) run_row(ROWS[i]);
    gen <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      interval_timer_in_use <= (c == 0);
      mod_rdy <= 1'b0;
      wb_xfer(1'b1, iwg_pkg::OFS_CFG, (c == 1) ? 32'h2 : 32'h0);
      rd = {31'h0, waveform_output_pin};
      wb_xfer(1'b1, iwg_pkg::OFS_CTRL, 32'h1);
      repeat (3) @(posedge clock);
      chk("refused claim", 32'h0, {31'h0, interval_timer_claim});
      chk("refused pin", rd, {31'h0, waveform_output_pin});
      wb_xfer(1'b0, iwg_pkg::OFS_STATUS, 32'h0);
      chk("refused flag", 32'h1, {31'h0, rd[2]});
      wb_xfer(1'b1, iwg_pkg::OFS_STATUS, 32'h4);
      interval_timer_in_use <= 1'b0;
    end
    wb_xfer(1'b1, iwg_pkg::OFS_CFG, 32'h0);
    wb_xfer(1'b1, iwg_pkg::OFS_COUNT, 32'h3);
    wb_xfer(1'b1, iwg_pkg::OFS_CTRL, 32'h1);
    repeat (50) @(posedge clock);
    chk("claim in run", 32'h1, {31'h0, interval_timer_claim});
    reset_n <= 1'b0;
    @(posedge clock);
    chk("outputs in mid-run reset", 32'h0, {28'h0, waveform_output_pin, waveform_output_pin_oe,
      carrier_out_en, interval_timer_claim});
    reset_n <= 1'b1;
    @(posedge clock);
    wb_xfer(1'b0, iwg_pkg::OFS_COUNT, 32'h0);
    chk("count after reset", 32'h1, rd);
    complete_run();
  end
endmodule

bind iwg_top iwg_top_asserts chk (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .interval_timer_in_use(interval_timer_in_use),
  .carrier_wave(carrier_wave), .waveform_output_pin(waveform_output_pin), .port_output_bit(port_output_bit),
  .waveform_output_pin_oe(waveform_output_pin_oe), .port_output_oe(port_output_oe),
  .carrier_compare_out_a(carrier_compare_out_a), .carrier_out_en(carrier_out_en),
  .interval_timer_claim(interval_timer_claim));

`default_nettype wire
